// [src/lsd_led_status_driver.sv]
// programmable status led driver with register port and pulse stretching
// the block keeps one 16-bit configuration word behind a plain
// register port. three selector fields pick what each led shows.
// continuous modes follow their status input one cycle late,
// because every led level is registered before it leaves.
// event modes pass through a pulse stretcher first, so a one
// cycle event is seen by the eye for the selected hold time.
// combined modes mix a solid primary level with a stretched
// secondary event: the event inverts the level for its hold.
// the test patterns come from two free-running blink counters
// that start low after reset and never stop.
//
// hazards and limits a user should know:
// - the status inputs are taken as same-clock logic; a source
//   from another clock must be synchronised before this block.
// - a selector change takes effect at once, while the stretch
//   timers keep running; a pending hold may show briefly in the
//   newly selected event mode.
// - hold times are approximate by nature; software must not
//   rely on an exact count.
// - reads return zero outside the cycle after the read strobe,
//   so a bus that ors several slaves needs no extra gating.
`timescale 1ns/10ps
module lsd_led_status_driver #(
  parameter int unsigned STRETCH_SHORT_CYC = lsd_pkg::LSD_STR_SHORT_CYC,
  parameter int unsigned STRETCH_LONG_CYC = lsd_pkg::LSD_STR_LONG_CYC,
  parameter int unsigned BLINK_FAST_CYC = lsd_pkg::LSD_BLINK_FAST_CYC,
  parameter int unsigned BLINK_SLOW_CYC = lsd_pkg::LSD_BLINK_SLOW_CYC
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire lsd_pkg::lsd_addr_t i_addr,
  input wire lsd_pkg::lsd_data_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output lsd_pkg::lsd_data_t o_rdata,
  input wire logic i_speed_100,
  input wire logic i_link_up,
  input wire logic i_full_duplex,
  input wire logic i_tx_active,
  input wire logic i_rx_active,
  input wire logic i_collision,
  output logic [lsd_pkg::LSD_NUM_LEDS-1:0] o_led
);
  import lsd_pkg::*;

  // ****************************************
  // types and state
  // ****************************************

  // every flip-flop of the block apart from the reset synchroniser
  // and the stretchers; the stretchers live in their own modules.
  // keeping one struct makes the reset value a single constant
  // and keeps next-state logic in one combinational process.
  typedef struct packed {
    lsd_data_t cfg;
    lsd_data_t rdata;
    lsd_cnt_t fast_cnt;
    lsd_cnt_t slow_cnt;
    logic fast_ph;
    logic slow_ph;
    logic [LSD_NUM_LEDS-1:0] led;
  } lsd_state_s;

  localparam lsd_state_s LSD_STATE_RST = '{
    cfg: LSD_CFG_RST,
    rdata: '0,
    fast_cnt: '0,
    slow_cnt: '0,
    fast_ph: 1'b0,
    slow_ph: 1'b0,
    led: '0
  };

  localparam lsd_cnt_t SHORT_HOLD = lsd_cnt_t'(STRETCH_SHORT_CYC);
  localparam lsd_cnt_t LONG_HOLD = lsd_cnt_t'(STRETCH_LONG_CYC);
  localparam lsd_cnt_t FAST_LAST = lsd_cnt_t'(BLINK_FAST_CYC - 1);
  localparam lsd_cnt_t SLOW_LAST = lsd_cnt_t'(BLINK_SLOW_CYC - 1);

  lsd_state_s s_q;
  lsd_state_s s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [LSD_NUM_LEDS-1:0] stretched;
  lsd_mode_e mode [LSD_NUM_LEDS];
  logic cfg_hit;
  logic stretch_en;
  lsd_cnt_t hold_now;

  // ****************************************
  // functions
  // ****************************************

  // event source that feeds the stretcher for a mode
  function automatic logic sel_event(
    input lsd_mode_e m,
    input logic tx,
    input logic rx,
    input logic col
  );
    logic ev;
    ev = 1'b0;
    case (m)
      LSD_M_TX: begin
        ev = tx;
      end
      LSD_M_RX, LSD_M_LINK_RX: begin
        ev = rx;
      end
      LSD_M_COL, LSD_M_DUP_COL: begin
        ev = col;
      end
      LSD_M_ACT, LSD_M_LINK_ACT: begin
        ev = rx | tx;
      end
      default: begin
        ev = 1'b0;
      end
    endcase
    return ev;
  endfunction

  // combined displays that stretch whatever the enable bit says
  function automatic logic is_combined(input lsd_mode_e m);
    return (m == LSD_M_LINK_RX) || (m == LSD_M_LINK_ACT) || (m == LSD_M_DUP_COL);
  endfunction

  // level the led takes for a mode
  function automatic logic led_value(
    input lsd_mode_e m,
    input logic str,
    input logic spd,
    input logic link,
    input logic dup,
    input logic fast,
    input logic slow
  );
    logic v;
    v = 1'b0;
    case (m)
      LSD_M_SPEED: begin
        v = spd;
      end
      LSD_M_LINK: begin
        v = link;
      end
      LSD_M_DUPLEX: begin
        v = dup;
      end
      LSD_M_TX, LSD_M_RX, LSD_M_COL, LSD_M_ACT: begin
        v = str;
      end
      LSD_M_ON: begin
        v = 1'b1;
      end
      LSD_M_OFF: begin
        v = 1'b0;
      end
      LSD_M_FAST: begin
        v = fast;
      end
      LSD_M_SLOW: begin
        v = slow;
      end
      LSD_M_LINK_RX, LSD_M_LINK_ACT: begin
        v = link ^ str;
      end
      LSD_M_DUP_COL: begin
        v = dup ^ str;
      end
      default: begin
        v = 1'b0;
      end
    endcase
    return v;
  endfunction

  // ****************************************
  // reset release
  // ****************************************

  // reset enters asynchronously, leaves on the clock.
  // two flops keep a late release edge from reaching part of the
  // state on one clock and the rest on the next.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ****************************************
  // configuration decode
  // ****************************************

  always_comb begin
    for (int i = 0; i < LSD_NUM_LEDS; i++) begin
      mode[i] = lsd_mode_e'(s_q.cfg[LSD_SEL_LSB[i] +: LSD_SEL_W]);
    end
  end

  assign stretch_en = s_q.cfg[LSD_STR_EN_BIT];

  assign hold_now = (s_q.cfg[LSD_PER_LSB +: LSD_PER_W] == LSD_PER_LONG) ? LONG_HOLD : SHORT_HOLD;

  assign cfg_hit = (i_addr == LSD_ADDR_LED_CONFIG);

  // ****************************************
  // pulse stretchers
  // ****************************************

  // one stretcher per led, fed by the selected event.
  // the stretcher always runs; whether its hold counts toward
  // the led depends on the enable bit or a combined mode.
  // the hold length is read live, so a period change applies
  // to the next event and not to one already being held.
  for (genvar g = 0; g < LSD_NUM_LEDS; g++) begin : g_led
    lsd_stretch_if sif ();

    assign sif.event_in = sel_event(mode[g], i_tx_active, i_rx_active, i_collision);
    assign sif.stretch_on = stretch_en | is_combined(mode[g]);
    assign sif.hold_cyc = hold_now;
    assign stretched[g] = sif.led_event;

    lsd_stretch u_stretch (
      .i_clock (i_clock),
      .i_reset_n (rst_n),
      .u (sif.unit)
    );
  end

  // ****************************************
  // next state
  // ****************************************

  always_comb begin
    s_d = s_q;

    // register write, whole word
    if (i_wr && cfg_hit) begin
      s_d.cfg = i_wdata;
    end

    // read data stand one cycle, zero otherwise
    s_d.rdata = '0;
    if (i_rd && cfg_hit) begin
      s_d.rdata = s_q.cfg;
    end

    // blink counters run free; the greater-or-equal compare
    // recovers even if a counter ever held an odd value.
    // fast blink half period
    if (s_q.fast_cnt >= FAST_LAST) begin
      s_d.fast_cnt = '0;
      s_d.fast_ph = ~s_q.fast_ph;
    end else begin
      s_d.fast_cnt = s_q.fast_cnt + LSD_CNT_ONE;
    end

    // slow blink half period
    if (s_q.slow_cnt >= SLOW_LAST) begin
      s_d.slow_cnt = '0;
      s_d.slow_ph = ~s_q.slow_ph;
    end else begin
      s_d.slow_cnt = s_q.slow_cnt + LSD_CNT_ONE;
    end

    for (int i = 0; i < LSD_NUM_LEDS; i++) begin
      s_d.led[i] = led_value(mode[i], stretched[i], i_speed_100, i_link_up,
                             i_full_duplex, s_q.fast_ph, s_q.slow_ph);
    end
  end

  // ****************************************
  // state register
  // ****************************************

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= LSD_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  // both outputs come straight from flops, so no glitch from the
  // decode reaches the pins or the register bus.
  assign o_rdata = s_q.rdata;
  assign o_led = s_q.led;

endmodule

// [src/lsd_pkg.sv]
// constants, types and register layout of the led status driver
package lsd_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned LSD_CLOCK_HZ = 40_000_000;
  localparam int unsigned LSD_HZ_PER_KHZ = 1000;
  localparam int unsigned LSD_CYC_PER_MS = LSD_CLOCK_HZ / LSD_HZ_PER_KHZ;
  localparam int unsigned LSD_STR_SHORT_MS = 30;
  localparam int unsigned LSD_STR_LONG_MS = 60;
  localparam int unsigned LSD_BLINK_FAST_MS = 50;
  localparam int unsigned LSD_BLINK_SLOW_MS = 200;
  localparam int unsigned LSD_STR_SHORT_CYC = LSD_STR_SHORT_MS * LSD_CYC_PER_MS;
  localparam int unsigned LSD_STR_LONG_CYC = LSD_STR_LONG_MS * LSD_CYC_PER_MS;
  localparam int unsigned LSD_BLINK_FAST_CYC = LSD_BLINK_FAST_MS * LSD_CYC_PER_MS;
  localparam int unsigned LSD_BLINK_SLOW_CYC = LSD_BLINK_SLOW_MS * LSD_CYC_PER_MS;
  localparam int LSD_CNT_W = 24;
  typedef logic [LSD_CNT_W-1:0] lsd_cnt_t;
  localparam lsd_cnt_t LSD_CNT_ONE = 24'h000001;

  // ****************************************
  // register bus
  // ****************************************
  localparam int LSD_ADDR_W = 5;
  localparam int LSD_DATA_W = 16;
  typedef logic [LSD_ADDR_W-1:0] lsd_addr_t;
  typedef logic [LSD_DATA_W-1:0] lsd_data_t;
  localparam lsd_addr_t LSD_ADDR_LED_CONFIG = 5'h14;

  // ****************************************
  // led_config fields
  // ****************************************
  localparam int LSD_NUM_LEDS = 3;
  localparam int LSD_SEL_W = 4;
  localparam int LSD_PER_W = 2;
  localparam int LSD_SEL_LSB [LSD_NUM_LEDS] = '{12, 8, 4};
  localparam int LSD_PER_LSB = 2;
  localparam int LSD_STR_EN_BIT = 1;
  localparam logic [LSD_PER_W-1:0] LSD_PER_SHORT = 2'h0;
  localparam logic [LSD_PER_W-1:0] LSD_PER_LONG = 2'h1;
  localparam logic [LSD_SEL_W-1:0] LSD_SEL1_RST = 4'h0;
  localparam logic [LSD_SEL_W-1:0] LSD_SEL2_RST = 4'h4;
  localparam logic [LSD_SEL_W-1:0] LSD_SEL3_RST = 4'h2;
  localparam logic LSD_STR_EN_RST = 1'b1;
  localparam logic LSD_RSV0_RST = 1'b0;
  localparam lsd_data_t LSD_CFG_RST = {LSD_SEL1_RST, LSD_SEL2_RST, LSD_SEL3_RST,
                                       LSD_PER_SHORT, LSD_STR_EN_RST, LSD_RSV0_RST};

  // ****************************************
  // selector codes
  // ****************************************
  typedef enum logic [LSD_SEL_W-1:0] {
    LSD_M_SPEED = 4'h0,
    LSD_M_TX = 4'h1,
    LSD_M_RX = 4'h2,
    LSD_M_COL = 4'h3,
    LSD_M_LINK = 4'h4,
    LSD_M_DUPLEX = 4'h5,
    LSD_M_UNUSED_A = 4'h6,
    LSD_M_ACT = 4'h7,
    LSD_M_ON = 4'h8,
    LSD_M_OFF = 4'h9,
    LSD_M_FAST = 4'ha,
    LSD_M_SLOW = 4'hb,
    LSD_M_LINK_RX = 4'hc,
    LSD_M_LINK_ACT = 4'hd,
    LSD_M_DUP_COL = 4'he,
    LSD_M_UNUSED_B = 4'hf
  } lsd_mode_e;

endpackage

// [src/lsd_stretch_if.sv]
// carrier between the led selector and one pulse stretcher
`timescale 1ns/10ps
interface lsd_stretch_if;
  import lsd_pkg::*;
  logic event_in;
  logic stretch_on;
  lsd_cnt_t hold_cyc;
  logic led_event;
  modport ctrl (output event_in, output stretch_on, output hold_cyc, input led_event);
  modport unit (input event_in, input stretch_on, input hold_cyc, output led_event);
endinterface

// [src/lsd_stretch.sv]
// pulse stretcher for one led event source
`timescale 1ns/10ps
module lsd_stretch (
  input wire logic i_clock,
  input wire logic i_reset_n,
  lsd_stretch_if.unit u
);
  import lsd_pkg::*;

  typedef struct packed {
    lsd_cnt_t remain;
    logic led;
  } lsd_str_s;

  lsd_str_s s_q;
  lsd_str_s s_d;

  always_comb begin
    s_d = s_q;
    if (u.event_in) begin
      s_d.remain = u.hold_cyc;
    end else if (s_q.remain != '0) begin
      s_d.remain = s_q.remain - LSD_CNT_ONE;
    end
    s_d.led = u.event_in | (u.stretch_on & (s_q.remain != '0));
  end

  // state register
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign u.led_event = s_q.led;
endmodule

// [testbench/lsd_props.sv]
// checker of the led status driver ports
`timescale 1ns/10ps
module lsd_props #(
  parameter int unsigned STRETCH_LONG_CYC = 40
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire lsd_pkg::lsd_addr_t i_addr,
  input wire lsd_pkg::lsd_data_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire lsd_pkg::lsd_data_t o_rdata,
  input wire logic i_speed_100,
  input wire logic i_link_up,
  input wire logic i_full_duplex,
  input wire logic i_tx_active,
  input wire logic i_rx_active,
  input wire logic i_collision,
  input wire logic [lsd_pkg::LSD_NUM_LEDS-1:0] o_led
);
  import lsd_pkg::*;
  lsd_data_t cfg_q;
  logic [2:0] rdy_q;
  int unsigned quiet_q;
  logic [3:0] s0;
  logic rx_st;
  assign s0 = cfg_q[15:12];
  assign rx_st = s0 == 4'h2 && cfg_q[1];
  // ****************************************
  // shadow config, reset release, rx quiet time
  // ****************************************
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_q <= LSD_CFG_RST;
      rdy_q <= 3'h0;
      quiet_q <= 0;
    end else begin
      rdy_q <= {rdy_q[1:0], 1'b1};
      if (i_wr && i_addr == LSD_ADDR_LED_CONFIG) begin
        cfg_q <= i_wdata;
      end
      quiet_q <= i_rx_active ? 0 : (quiet_q > STRETCH_LONG_CYC + 4 ? quiet_q : quiet_q + 1);
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data not zero when idle");
  AST_RD_UNMAPPED: assert property ($past(i_rd) && $past(i_addr) != LSD_ADDR_LED_CONFIG |-> o_rdata == '0)
    else $error("unmapped read not zero");
  AST_RD_CFG: assert property (rdy_q[2] && $past(i_rd) && $past(i_addr) == LSD_ADDR_LED_CONFIG |-> o_rdata == $past(cfg_q))
    else $error("config read wrong");
  AST_CONT: assert property (rdy_q[2] && $past(s0) inside {4'h0, 4'h4, 4'h5} |-> o_led[0] == ($past(s0) == 4'h0 ?
    $past(i_speed_100) : ($past(s0) == 4'h4 ? $past(i_link_up) : $past(i_full_duplex))))
    else $error("continuous led wrong");
  AST_FORCE_ON: assert property (rdy_q[2] && $past(s0) == 4'h8 |-> o_led[0])
    else $error("forced on led dark");
  AST_FORCE_OFF: assert property (rdy_q[2] && $past(s0) inside {4'h9, 4'h6, 4'hf} |-> !o_led[0])
    else $error("off or unused led lit");
  AST_HOLD: assert property (rdy_q[2] && rx_st && i_rx_active ##1 rx_st [*4] |-> o_led[0])
    else $error("stretched led dropped early");
  AST_EXPIRE: assert property (rdy_q[2] && $past(s0) == 4'h2 && quiet_q > STRETCH_LONG_CYC + 4 |-> !o_led[0])
    else $error("stretched led never expired");
  AST_NOSTR: assert property (rdy_q[2] && s0 == 4'h2 && !cfg_q[1] && !i_rx_active [*3] |-> !o_led[0])
    else $error("led stretched while disabled");
  COV_RW: cover property (i_wr ##1 i_rd);
  COV_RX: cover property (rx_st && i_rx_active);
  COV_COL: cover property (s0 == 4'he && i_collision);
endmodule
bind lsd_led_status_driver lsd_props #(.STRETCH_LONG_CYC(STRETCH_LONG_CYC)) i_lsd_props (.i_clock(i_clock),
  .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_speed_100(i_speed_100), .i_link_up(i_link_up), .i_full_duplex(i_full_duplex), .i_tx_active(i_tx_active),
  .i_rx_active(i_rx_active), .i_collision(i_collision), .o_led(o_led));

// [testbench/lsd_led_lamp.sv]
// lamp model of the three status leds at the block's pins
`timescale 1ns/10ps
module lsd_led_lamp (
  input wire logic i_clock,
  input wire logic [2:0] i_led,
  output logic [2:0] o_lit,
  output int o_burst
);
  int run_q = 0;
  // lamps follow the pins; burst is the last lit spell of lamp 0
  always @(posedge i_clock) begin
    o_lit <= i_led;
    if (i_led[0] === 1'b1) begin
      run_q <= run_q + 1;
    end else if (run_q != 0) begin
      o_burst <= run_q;
      run_q <= 0;
    end
  end
endmodule

// [testbench/tb_lsd_led_status_driver.sv]
// self-checking bench of the led status driver
`timescale 1ns/10ps
module tb_lsd_led_status_driver;
  import lsd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  lsd_addr_t addr = '0;
  lsd_data_t wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  lsd_data_t rdata;
  lsd_data_t d;
  logic spd = 1'b1;
  logic link = 1'b1;
  logic dup = 1'b1;
  logic tx = 1'b0;
  logic rx = 1'b0;
  logic col = 1'b0;
  logic [2:0] led;
  logic [2:0] lit;
  int burst;
  int mismatches = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  lsd_led_status_driver #(.STRETCH_SHORT_CYC(20), .STRETCH_LONG_CYC(40), .BLINK_FAST_CYC(8),
    .BLINK_SLOW_CYC(16)) i_lsd_led_status_driver (.i_clock(clk), .i_reset_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_speed_100(spd), .i_link_up(link),
    .i_full_duplex(dup), .i_tx_active(tx), .i_rx_active(rx), .i_collision(col), .o_led(led));
  lsd_led_lamp i_lsd_led_lamp (.i_clock(clk), .i_led(led), .o_lit(lit), .o_burst(burst));
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr_reg(input lsd_addr_t a, input lsd_data_t v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input lsd_addr_t a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task pulse(input logic [2:0] m);
    @(posedge clk);
    {tx, rx, col} <= m;
    @(posedge clk);
    {tx, rx, col} <= 3'h0;
  endtask
  // register defaults, unmapped place and readback
  task t_regs;
    chk("led", lit, 3'h3);
    rd_reg(5'h14);
    chk("cfg", d, 16'h0422);
    wr_reg(5'h13, 16'hffff);
    rd_reg(5'h13);
    chk("unmapped", d, 16'h0000);
    wr_reg(5'h14, 16'hffff);
    rd_reg(5'h14);
    chk("cfg", d, 16'hffff);
  endtask
  // every selector code with status idle, two input patterns
  task t_modes;
    logic p;
    logic e;
    int n;
    logic prev;
    for (int k = 0; k < 32; k++) begin
      p = k[4];
      spd <= p;
      link <= ~p;
      dup <= p;
      wr_reg(5'h14, {k[3:0], 8'h99, 4'h2});
      tick(30);
      if (k[3:1] == 3'h5) begin
        n = 0;
        prev = led[0];
        repeat (32) begin
          tick(1);
          if (led[0] !== prev) n++;
          prev = led[0];
        end
        chk("blink", 16'(n), k[0] ? 16'h2 : 16'h4);
      end else begin
        case (k[3:0])
          4'h0, 4'h5, 4'he: e = p;
          4'h4, 4'hc, 4'hd: e = ~p;
          4'h8: e = 1'b1;
          default: e = 1'b0;
        endcase
        chk("mode", led, {2'h0, e});
      end
    end
  endtask
  // stretch length per period code, and restart on a new event
  task t_stretch;
    int h;
    for (int per = 0; per < 4; per++) begin
      h = per == 1 ? 40 : 20;
      wr_reg(5'h14, {4'h2, 8'h99, per[1:0], 2'h2});
      pulse(3'h2);
      tick(60);
      chk("burst", burst >= h && burst <= h + 3, 1'b1);
      pulse(3'h2);
      tick(10);
      pulse(3'h2);
      tick(60);
      chk("restart", burst >= h + 10 && burst <= h + 15, 1'b1);
    end
  endtask
  // stretching off, combined modes still stretch
  task t_nostr;
    link <= 1'b1;
    dup <= 1'b1;
    wr_reg(5'h14, {12'h1de, 4'h0});
    tick(30);
    chk("solid", led, 3'h6);
    pulse(3'h5);
    tick(6);
    chk("blink", led, 3'h0);
    chk("burst", burst, 16'h1);
    tick(30);
    chk("solid", led, 3'h6);
    wr_reg(5'h14, 16'h2990);
    tick(30);
    pulse(3'h2);
    tick(6);
    chk("rx plain", burst, 16'h1);
  endtask
  task summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    tick(6);
    t_regs();
    t_modes();
    t_stretch();
    t_nostr();
    summarize();
  end
endmodule
